// *** gptlm_defs.svh ***
// constants for the general-purpose timer load, match and prescale block
//
// Contract
// - a load written while counting goes into the running counter one clock after the write
// - software reads back the last programmed load value of either half
// - edge-count capture compares count with match and raises an event
// - pulse-width mode uses the match value as the duty threshold
// - prescaler divides only in 16-bit modes, no effect when joined
// - prescale setting is unsigned 0 to 255 inclusive
// - in RTC mode the RTC enable command starts counting
// - outside RTC mode the RTC enable command does nothing
// - the RTC disable command stops RTC counting
// - reading the current value returns the live counter of that half
// - software reads back the match value of each half separately
// - software reads back the prescale setting of each half
// - load, match and prescale writes target first, second or both halves
// - with stall enabled counting freezes while the core is halted in debug
`ifndef GPTLM_DEFS_SVH
`define GPTLM_DEFS_SVH

`define GPTLM_SEL_A 2'h1
`define GPTLM_SEL_B 2'h2
`define GPTLM_SEL_BOTH 2'h3
`define GPTLM_HALF_W 16
`define GPTLM_FULL_W 32
`define GPTLM_PRE_W 8
`define GPTLM_LOAD_RST 32'hffffffff
`define GPTLM_MATCH_RST 32'h00000000
`define GPTLM_PRE_RST 8'h00

`endif

// *** gptlm_pkg.sv ***
// types for the general-purpose timer load, match and prescale block
package gptlm_pkg;

    typedef enum logic [2:0]
    {
        GPTLM_ONESHOT = 3'b000,
        GPTLM_PERIODIC = 3'b001,
        GPTLM_CAP_COUNT = 3'b010,
        GPTLM_CAP_TIME = 3'b011,
        GPTLM_PWM = 3'b100,
        GPTLM_RTC = 3'b101
    } gptlm_mode_t;

    typedef enum logic [1:0]
    {
        GPTLM_RD_LOAD = 2'b00,
        GPTLM_RD_MATCH = 2'b01,
        GPTLM_RD_PRE = 2'b10,
        GPTLM_RD_VALUE = 2'b11
    } gptlm_rd_t;

endpackage : gptlm_pkg

// *** gptlm_prescale.sv ***
// input clock prescaler giving a one-cycle count tick
`timescale 1ns/100ps
module gptlm_prescale #(
    parameter int PW = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic en,
    input wire logic [PW-1:0] pre,
    // tick
    output logic tick
);

    logic [PW-1:0] cnt_r;

    // tick every pre+1 cycles while enabled
    assign tick = en && (cnt_r == pre);

    always_ff @(posedge clock)
    begin
        if (rst || !en || tick)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + {{(PW-1){1'b0}}, 1'b1};
        end
    end

endmodule : gptlm_prescale

// *** gptlm_half.sv ***
// one timer half: counter, timeout, match event and pulse-width output
`timescale 1ns/100ps
module gptlm_half #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic tick,
    input wire logic run,
    input wire logic start,
    input wire logic load_go,
    input wire gptlm_pkg::gptlm_mode_t mode,
    input wire logic [W-1:0] load_val,
    input wire logic [W-1:0] match_val,
    input wire logic cap_edge,
    // state
    output logic [W-1:0] cnt_r,
    output logic timeout_r,
    output logic match_r,
    output logic pwm_r
);

    logic down_mode;
    logic [W-1:0] one;

    assign one = {{(W-1){1'b0}}, 1'b1};
    assign down_mode = (mode != gptlm_pkg::GPTLM_CAP_COUNT) && (mode != gptlm_pkg::GPTLM_RTC);

    // counter
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cnt_r <= '0;
        end
        else if (load_go || start)
        begin
            cnt_r <= load_val;
        end
        else if (run)
        begin
            case (mode)
                gptlm_pkg::GPTLM_CAP_COUNT:
                begin
                    if (cap_edge)
                    begin
                        cnt_r <= cnt_r - one;
                    end
                end
                gptlm_pkg::GPTLM_RTC:
                begin
                    if (tick)
                    begin
                        cnt_r <= cnt_r + one;
                    end
                end
                gptlm_pkg::GPTLM_ONESHOT:
                begin
                    if (tick && cnt_r != '0)
                    begin
                        cnt_r <= cnt_r - one;
                    end
                end
                default:
                begin
                    if (tick)
                    begin
                        cnt_r <= (cnt_r == '0) ? load_val : cnt_r - one;
                    end
                end
            endcase
        end
    end

    // timeout on reaching zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            timeout_r <= 1'b0;
        end
        else
        begin
            timeout_r <= run && tick && down_mode && (cnt_r == one) && !load_go && !start;
        end
    end

    // match event
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            match_r <= 1'b0;
        end
        else if (run && !load_go && !start && mode == gptlm_pkg::GPTLM_CAP_COUNT)
        begin
            match_r <= cap_edge && (cnt_r - one == match_val);
        end
        else if (run && !load_go && !start && mode == gptlm_pkg::GPTLM_RTC)
        begin
            match_r <= tick && (cnt_r + one == match_val);
        end
        else
        begin
            match_r <= 1'b0;
        end
    end

    // duty threshold
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pwm_r <= 1'b0;
        end
        else
        begin
            pwm_r <= (mode == gptlm_pkg::GPTLM_PWM) && run && (cnt_r > match_val);
        end
    end

endmodule : gptlm_half

// *** gptlm_top.sv ***
// timer pair with load, match, prescale, readback and rtc start and stop
`timescale 1ns/100ps
`include "gptlm_defs.svh"
module gptlm_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration
    input wire logic cfg_join,
    input wire gptlm_pkg::gptlm_mode_t mode_a,
    input wire gptlm_pkg::gptlm_mode_t mode_b,
    input wire logic en_a,
    input wire logic en_b,
    input wire logic stall_a,
    input wire logic stall_b,
    input wire logic dbg_halt,
    // writes
    input wire logic [1:0] wr_sel,
    input wire logic load_wr,
    input wire logic match_wr,
    input wire logic pre_wr,
    input wire logic [31:0] wr_data,
    // rtc commands
    input wire logic rtc_start,
    input wire logic rtc_stop,
    // reads
    input wire logic rd_req,
    input wire logic rd_sel_b,
    input wire gptlm_pkg::gptlm_rd_t rd_what,
    output logic [31:0] rd_data_r,
    output logic rd_valid_r,
    // capture edges
    input wire logic cap_edge_a,
    input wire logic cap_edge_b,
    // timer outputs
    output logic [31:0] cnt_a,
    output logic [15:0] cnt_b,
    output logic timeout_a,
    output logic timeout_b,
    output logic match_a,
    output logic match_b,
    output logic pwm_a,
    output logic pwm_b,
    output logic rtc_run_r
);

    logic [31:0] load_a_r;
    logic [15:0] load_b_r;
    logic [31:0] match_a_r;
    logic [15:0] match_b_r;
    logic [`GPTLM_PRE_W-1:0] pre_a_r;
    logic [`GPTLM_PRE_W-1:0] pre_b_r;
    logic load_go_a_r;
    logic load_go_b_r;
    logic en_a_d_r;
    logic en_b_d_r;
    logic rtc_mode;
    logic run_a;
    logic run_b;
    logic start_a;
    logic start_b;
    logic pre_tick_a;
    logic pre_tick_b;
    logic tick_a;
    logic [31:0] load_val_a;
    logic [31:0] match_val_a;

    function automatic logic hits(input logic [1:0] sel, input logic half_b);
        hits = half_b ? sel[1] : sel[0];
    endfunction : hits

    assign rtc_mode = cfg_join && (mode_a == gptlm_pkg::GPTLM_RTC);
    assign run_a = en_a && !(stall_a && dbg_halt) && (!rtc_mode || rtc_run_r);
    assign run_b = en_b && !cfg_join && !(stall_b && dbg_halt);
    assign start_a = en_a && !en_a_d_r;
    assign start_b = en_b && !en_b_d_r && !cfg_join;
    assign tick_a = cfg_join ? 1'b1 : pre_tick_a;
    assign load_val_a = cfg_join ? load_a_r : {16'h0000, load_a_r[15:0]};
    assign match_val_a = cfg_join ? match_a_r : {16'h0000, match_a_r[15:0]};

    // load registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            load_a_r <= `GPTLM_LOAD_RST;
            load_b_r <= 16'(`GPTLM_LOAD_RST >> 16);
        end
        else if (load_wr)
        begin
            if (hits(wr_sel, 1'b0))
            begin
                load_a_r <= wr_data;
            end
            if (hits(wr_sel, 1'b1))
            begin
                load_b_r <= wr_data[15:0];
            end
        end
    end

    // transfer into a running counter one clock after the load write
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            load_go_a_r <= 1'b0;
            load_go_b_r <= 1'b0;
        end
        else
        begin
            load_go_a_r <= load_wr && hits(wr_sel, 1'b0) && run_a;
            load_go_b_r <= load_wr && hits(wr_sel, 1'b1) && run_b;
        end
    end

    // match registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            match_a_r <= `GPTLM_MATCH_RST;
            match_b_r <= 16'h0000;
        end
        else if (match_wr)
        begin
            if (hits(wr_sel, 1'b0))
            begin
                match_a_r <= wr_data;
            end
            if (hits(wr_sel, 1'b1))
            begin
                match_b_r <= wr_data[15:0];
            end
        end
    end

    // prescale registers, eight bits hold 0 to 255
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pre_a_r <= `GPTLM_PRE_RST;
            pre_b_r <= `GPTLM_PRE_RST;
        end
        else if (pre_wr)
        begin
            if (hits(wr_sel, 1'b0))
            begin
                pre_a_r <= wr_data[7:0];
            end
            if (hits(wr_sel, 1'b1))
            begin
                pre_b_r <= wr_data[7:0];
            end
        end
    end

    // enable edge detect
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            en_a_d_r <= 1'b0;
            en_b_d_r <= 1'b0;
        end
        else
        begin
            en_a_d_r <= en_a;
            en_b_d_r <= en_b;
        end
    end

    // rtc run flag, stop wins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rtc_run_r <= 1'b0;
        end
        else if (rtc_stop || !rtc_mode)
        begin
            rtc_run_r <= 1'b0;
        end
        else if (rtc_start)
        begin
            rtc_run_r <= 1'b1;
        end
    end

    // readback
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_data_r <= 32'h00000000;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= rd_req;
            if (rd_req)
            begin
                case (rd_what)
                    gptlm_pkg::GPTLM_RD_LOAD:
                        rd_data_r <= rd_sel_b ? {16'h0000, load_b_r} : load_a_r;
                    gptlm_pkg::GPTLM_RD_MATCH:
                        rd_data_r <= rd_sel_b ? {16'h0000, match_b_r} : match_a_r;
                    gptlm_pkg::GPTLM_RD_PRE:
                        rd_data_r <= {24'h000000, rd_sel_b ? pre_b_r : pre_a_r};
                    gptlm_pkg::GPTLM_RD_VALUE:
                        rd_data_r <= rd_sel_b ? {16'h0000, cnt_b} : cnt_a;
                    default:
                        rd_data_r <= 32'h00000000;
                endcase
            end
        end
    end

    gptlm_prescale #(.PW(`GPTLM_PRE_W)) u_pre_a (
        .clock(clock),
        .rst(rst),
        .en(run_a && !cfg_join),
        .pre(pre_a_r),
        .tick(pre_tick_a)
    );

    gptlm_prescale #(.PW(`GPTLM_PRE_W)) u_pre_b (
        .clock(clock),
        .rst(rst),
        .en(run_b),
        .pre(pre_b_r),
        .tick(pre_tick_b)
    );

    gptlm_half #(.W(`GPTLM_FULL_W)) u_half_a (
        .clock(clock),
        .rst(rst),
        .tick(tick_a),
        .run(run_a),
        .start(start_a),
        .load_go(load_go_a_r),
        .mode(mode_a),
        .load_val(load_val_a),
        .match_val(match_val_a),
        .cap_edge(cap_edge_a),
        .cnt_r(cnt_a),
        .timeout_r(timeout_a),
        .match_r(match_a),
        .pwm_r(pwm_a)
    );

    gptlm_half #(.W(`GPTLM_HALF_W)) u_half_b (
        .clock(clock),
        .rst(rst),
        .tick(pre_tick_b),
        .run(run_b),
        .start(start_b),
        .load_go(load_go_b_r),
        .mode(mode_b),
        .load_val(load_b_r),
        .match_val(match_b_r),
        .cap_edge(cap_edge_b),
        .cnt_r(cnt_b),
        .timeout_r(timeout_b),
        .match_r(match_b),
        .pwm_r(pwm_b)
    );

    // checks
    property p_load_run;
        @(posedge clock) disable iff (rst)
        load_wr && hits(wr_sel, 1'b0) && run_a && cfg_join && !start_a
            |=> ##1 cnt_a == $past(wr_data, 2);
    endproperty
    a_load_run: assert property (p_load_run) else $error("running load not taken");

    property p_load_rb;
        @(posedge clock) disable iff (rst)
        rd_req && rd_what == gptlm_pkg::GPTLM_RD_LOAD && !rd_sel_b |=> rd_data_r == $past(load_a_r);
    endproperty
    a_load_rb: assert property (p_load_rb) else $error("load readback wrong");

    property p_match_rb;
        @(posedge clock) disable iff (rst)
        rd_req && rd_what == gptlm_pkg::GPTLM_RD_MATCH && rd_sel_b
            |=> rd_valid_r && rd_data_r == {16'h0000, $past(match_b_r)};
    endproperty
    a_match_rb: assert property (p_match_rb) else $error("match readback wrong");

    property p_pre_rb;
        @(posedge clock) disable iff (rst)
        rd_req && rd_what == gptlm_pkg::GPTLM_RD_PRE && rd_sel_b
            |=> rd_data_r == {24'h000000, $past(pre_b_r)};
    endproperty
    a_pre_rb: assert property (p_pre_rb) else $error("prescale readback wrong");

    property p_value_rb;
        @(posedge clock) disable iff (rst)
        rd_req && rd_what == gptlm_pkg::GPTLM_RD_VALUE && !rd_sel_b |=> rd_data_r == $past(cnt_a);
    endproperty
    a_value_rb: assert property (p_value_rb) else $error("value readback wrong");

    property p_both;
        @(posedge clock) disable iff (rst)
        pre_wr && wr_sel == `GPTLM_SEL_BOTH |=> pre_a_r == pre_b_r && pre_a_r == $past(wr_data[7:0]);
    endproperty
    a_both: assert property (p_both) else $error("both-half write missed");

    property p_join_tick;
        @(posedge clock) disable iff (rst)
        cfg_join && run_a && mode_a == gptlm_pkg::GPTLM_PERIODIC && cnt_a != 32'h00000000
            && !load_go_a_r && !start_a |=> cnt_a == $past(cnt_a) - 32'h00000001;
    endproperty
    a_join_tick: assert property (p_join_tick) else $error("prescaler active when joined");

    property p_rtc_start;
        @(posedge clock) disable iff (rst)
        rtc_start && rtc_mode && !rtc_stop ##1 rtc_mode |-> rtc_run_r;
    endproperty
    a_rtc_start: assert property (p_rtc_start) else $error("rtc did not start");

    property p_rtc_noeff;
        @(posedge clock) disable iff (rst)
        rtc_start && !rtc_mode |=> !rtc_run_r;
    endproperty
    a_rtc_noeff: assert property (p_rtc_noeff) else $error("rtc start acted outside rtc mode");

    property p_rtc_stop;
        @(posedge clock) disable iff (rst)
        rtc_stop |=> !rtc_run_r;
    endproperty
    a_rtc_stop: assert property (p_rtc_stop) else $error("rtc did not stop");

    property p_stall;
        @(posedge clock) disable iff (rst)
        stall_a && dbg_halt && !load_go_a_r && !start_a |=> cnt_a == $past(cnt_a);
    endproperty
    a_stall: assert property (p_stall) else $error("counter moved in debug stall");

    property p_start_load;
        @(posedge clock) disable iff (rst)
        start_a |=> cnt_a == $past(load_val_a);
    endproperty
    a_start_load: assert property (p_start_load) else $error("held load not used at enable");

    cov_load_run: cover property (@(posedge clock) load_go_a_r);
    cov_rtc: cover property (@(posedge clock) rtc_start && rtc_mode ##[1:20] rtc_stop);
    cov_match: cover property (@(posedge clock) match_a || match_b);
    cov_pwm: cover property (@(posedge clock) pwm_b ##1 !pwm_b);

endmodule : gptlm_top

// *** gptlm_core_model.sv ***
// processor-side model issuing writes, reads and rtc commands
`timescale 1ns/100ps
`include "gptlm_defs.svh"
module gptlm_core_model (
    // clock and mode
    input wire logic clock,
    input wire logic cfg_join,
    // writes
    output logic [1:0] wr_sel,
    output logic load_wr,
    output logic match_wr,
    output logic pre_wr,
    output logic [31:0] wr_data,
    // rtc commands
    output logic rtc_start,
    output logic rtc_stop,
    // reads
    output logic rd_req,
    output logic rd_sel_b,
    output gptlm_pkg::gptlm_rd_t rd_what,
    input wire logic [31:0] rd_data_r,
    input wire logic rd_valid_r
);
    initial
    begin
        {wr_sel, load_wr, match_wr, pre_wr, rtc_start, rtc_stop, rd_req, rd_sel_b} = '0;
        wr_data = 32'h0;
        rd_what = gptlm_pkg::GPTLM_RD_LOAD;
    end

    // k: 0 load, 1 match, 2 prescale, 3 rtc start, 4 rtc stop
    task automatic put(input int k, input logic [1:0] sel, input logic [31:0] d);
        @(posedge clock);
        wr_sel <= cfg_join ? `GPTLM_SEL_A : sel;
        wr_data <= (k == 2) ? {24'h0, d[7:0]} : d;
        load_wr <= (k == 0);
        match_wr <= (k == 1);
        pre_wr <= (k == 2);
        rtc_start <= (k == 3);
        rtc_stop <= (k == 4);
        @(posedge clock);
        {load_wr, match_wr, pre_wr, rtc_start, rtc_stop} <= '0;
        wr_data <= ~d;
    endtask : put

    // one read, answer taken one edge after the request
    task automatic get(input logic b, input int w, output logic [31:0] d, output logic ok);
        @(posedge clock);
        rd_req <= 1'b1;
        rd_sel_b <= b & ~cfg_join;
        rd_what <= gptlm_pkg::gptlm_rd_t'(w[1:0]);
        @(posedge clock);
        rd_req <= 1'b0;
        #1;
        ok = (rd_valid_r === 1'b1);
        d = rd_data_r;
    endtask : get
endmodule : gptlm_core_model

// *** test_gp_timer_load_match_prescale.sv ***
// self-checking bench for the timer load, match and prescale block
`timescale 1ns/100ps
module test_gp_timer_load_match_prescale;
    logic clock, rst, cfg_join, en_a, en_b, stall_a, stall_b, dbg_halt;
    gptlm_pkg::gptlm_mode_t mode_a, mode_b;
    logic [1:0] wr_sel;
    logic load_wr, match_wr, pre_wr, rtc_start, rtc_stop, rd_req, rd_sel_b, rd_valid_r;
    logic [31:0] wr_data, rd_data_r, cnt_a;
    gptlm_pkg::gptlm_rd_t rd_what;
    logic cap_edge_a, cap_edge_b, timeout_a, timeout_b, match_a, match_b;
    logic pwm_a, pwm_b, rtc_run_r;
    logic [15:0] cnt_b;
    int bad_count = 0;
    int total_checks = 0;

    gptlm_top gptlm_top_i (.*);
    gptlm_core_model gptlm_core_model_i (.*);

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rb(input logic b, input int w, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic ok;
        gptlm_core_model_i.get(b, w, d, ok);
        chk({nm, "_valid"}, 32'h1, {31'h0, ok});
        chk(nm, e, d);
    endtask : rb

    task automatic wait_a(input logic [15:0] v, input string nm);
        for (int i = 0; i < 8 && cnt_a[15:0] !== v; i++)
            @(negedge clock);
        chk(nm, {16'h0, v}, {16'h0, cnt_a[15:0]});
        if (cnt_a[15:0] !== v)
            finish_test();
    endtask : wait_a

    task automatic gap(input int e, input string nm);
        logic [31:0] c;
        int n;
        repeat (2)
        begin
            c = cnt_a;
            n = 0;
            while (cnt_a === c && n < 600)
            begin
                @(negedge clock);
                n++;
            end
        end
        chk(nm, e, n);
        if (n >= 600)
            finish_test();
    endtask : gap

    task automatic sc_reset_vals();
        rb(0, 0, 32'hffffffff, "load_a");
        rb(1, 0, 32'h0000ffff, "load_b");
        rb(1, 1, 32'h0, "match_b");
        rb(0, 2, 32'h0, "pre_a");
    endtask : sc_reset_vals

    task automatic sc_select();
        gptlm_core_model_i.put(0, 2'h3, 32'h1234abcd);
        rb(0, 0, 32'h1234abcd, "load_both_a");
        rb(1, 0, 32'h0000abcd, "load_both_b");
        gptlm_core_model_i.put(1, 2'h1, 32'h11);
        gptlm_core_model_i.put(1, 2'h2, 32'h22);
        rb(0, 1, 32'h11, "match_a");
        rb(1, 1, 32'h22, "match_b");
        gptlm_core_model_i.put(2, 2'h3, 32'hff);
        gptlm_core_model_i.put(2, 2'h1, 32'h0);
        rb(0, 2, 32'h0, "pre_a");
        rb(1, 2, 32'hff, "pre_b");
    endtask : sc_select

    task automatic sc_load_run();
        logic [31:0] d;
        logic ok;
        logic [15:0] c;
        @(posedge clock);
        mode_a <= gptlm_pkg::GPTLM_PERIODIC;
        gptlm_core_model_i.put(0, 2'h1, 32'h40);
        @(posedge clock);
        en_a <= 1'b1;
        wait_a(16'h40, "start_cnt");
        gptlm_core_model_i.get(0, 3, d, ok);
        #1;
        c = cnt_a[15:0];
        chk("value_live", 32'h1, {31'h0, ok && (d[15:0] - c) <= 16'h3});
        gptlm_core_model_i.put(0, 2'h1, 32'h300);
        wait_a(16'h300, "load_running");
    endtask : sc_load_run

    task automatic sc_prescale();
        gptlm_core_model_i.put(2, 2'h1, 32'h3);
        gap(4, "pre_gap16");
        @(posedge clock);
        cfg_join <= 1'b1;
        gptlm_core_model_i.put(0, 2'h1, 32'h12345);
        gap(1, "pre_gap32");
        rb(1, 0, 32'h12345, "join_load");
    endtask : sc_prescale

    task automatic sc_capture();
        int ha, hb;
        @(posedge clock);
        {cfg_join, en_a} <= 2'b00;
        mode_a <= gptlm_pkg::GPTLM_CAP_COUNT;
        mode_b <= gptlm_pkg::GPTLM_CAP_COUNT;
        gptlm_core_model_i.put(2, 2'h3, 32'h0);
        gptlm_core_model_i.put(0, 2'h3, 32'ha);
        gptlm_core_model_i.put(1, 2'h3, 32'h7);
        {en_a, en_b} <= 2'b11;
        repeat (3) @(posedge clock);
        for (int i = 1; i <= 4; i++)
        begin
            {cap_edge_a, cap_edge_b} <= 2'b11;
            @(posedge clock);
            {cap_edge_a, cap_edge_b} <= 2'b00;
            {ha, hb} = '0;
            repeat (4)
            begin
                @(negedge clock);
                ha += match_a;
                hb += match_b;
            end
            chk("match_a_hits", i == 3, ha);
            chk("match_b_hits", i == 3, hb);
            @(posedge clock);
        end
        rb(0, 3, 32'h6, "value_a");
        rb(1, 3, 32'h6, "value_b");
    endtask : sc_capture

    task automatic sc_pwm();
        int h = 0;
        int hb = 0;
        int t = 0;
        int tb = 0;
        @(posedge clock);
        {en_a, en_b} <= 2'b00;
        mode_a <= gptlm_pkg::GPTLM_PWM;
        mode_b <= gptlm_pkg::GPTLM_PWM;
        gptlm_core_model_i.put(0, 2'h3, 32'h20);
        gptlm_core_model_i.put(1, 2'h3, 32'h10);
        {en_a, en_b} <= 2'b11;
        repeat (40) @(negedge clock);
        repeat (66)
        begin
            @(negedge clock);
            h += pwm_a;
            hb += pwm_b;
            t += timeout_a;
            tb += timeout_b;
        end
        chk("pwm_duty", 32, h);
        chk("pwm_duty_b", 32, hb);
        chk("timeout_a", 2, t);
        chk("timeout_b", 2, tb);
    endtask : sc_pwm

    task automatic sc_stall();
        logic [31:0] c;
        @(posedge clock);
        mode_a <= gptlm_pkg::GPTLM_PERIODIC;
        gptlm_core_model_i.put(0, 2'h1, 32'h8000);
        repeat (4) @(posedge clock);
        {stall_a, stall_b, dbg_halt} <= 3'b111;
        repeat (2) @(negedge clock);
        c = cnt_a;
        repeat (5) @(negedge clock);
        chk("stall_freeze", c, cnt_a);
        @(posedge clock);
        stall_a <= 1'b0;
        repeat (2) @(negedge clock);
        c = cnt_a;
        repeat (3) @(negedge clock);
        chk("halt_runs", c - 32'h3, cnt_a);
        @(posedge clock);
        {stall_b, dbg_halt} <= 2'b00;
    endtask : sc_stall

    task automatic sc_rtc();
        logic [31:0] c;
        @(posedge clock);
        {en_a, cfg_join} <= 2'b11;
        gptlm_core_model_i.put(3, 2'h1, 32'h0);
        @(negedge clock);
        chk("rtc_ignored", 32'h0, {31'h0, rtc_run_r});
        @(posedge clock);
        mode_a <= gptlm_pkg::GPTLM_RTC;
        gptlm_core_model_i.put(3, 2'h1, 32'h0);
        @(negedge clock);
        chk("rtc_on", 32'h1, {31'h0, rtc_run_r});
        c = cnt_a;
        repeat (5) @(negedge clock);
        chk("rtc_count", c + 32'h5, cnt_a);
        gptlm_core_model_i.put(4, 2'h1, 32'h0);
        @(negedge clock);
        chk("rtc_off", 32'h0, {31'h0, rtc_run_r});
        c = cnt_a;
        repeat (3) @(negedge clock);
        chk("rtc_held", c, cnt_a);
    endtask : sc_rtc

    initial
    begin
        rst = 1'b1;
        {cfg_join, en_a, en_b, stall_a, stall_b, dbg_halt, cap_edge_a, cap_edge_b} = '0;
        mode_a = gptlm_pkg::GPTLM_ONESHOT;
        mode_b = gptlm_pkg::GPTLM_ONESHOT;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        sc_reset_vals();
        sc_select();
        sc_load_run();
        sc_prescale();
        sc_capture();
        sc_pwm();
        sc_stall();
        sc_rtc();
        finish_test();
    end
endmodule : test_gp_timer_load_match_prescale
